// file: common/adcacm_pkg.sv
// Purpose: Shared constants for the auto-conversion monitor block.
// Assumes: 100 MHz system clock, APB register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package adcacm_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONV_CONTROL_A = 8'h00;
	localparam logic [7:0] OFF_CONV_CONTROL_B = 8'h04;
	localparam logic [7:0] OFF_RESULT_LOW     = 8'h08;
	localparam logic [7:0] OFF_RESULT_HIGH    = 8'h0c;
	localparam logic [7:0] OFF_AUTO_CTRL      = 8'h10;
	localparam logic [7:0] OFF_AUTO_EVT       = 8'h14;
	localparam logic [7:0] OFF_ULIM_LO        = 8'h18;
	localparam logic [7:0] OFF_ULIM_HI        = 8'h1c;
	localparam logic [7:0] OFF_LLIM_LO        = 8'h20;
	localparam logic [7:0] OFF_LLIM_HI        = 8'h24;
	// conv_control_a fields
	localparam int CA_START     = 7;
	localparam int CA_DONE_N    = 6;
	localparam int CA_POWER_OFF = 5;
	// conv_control_b fields
	localparam int CB_IRQ_FLAG  = 0;
	localparam int CB_IRQ_EN    = 1;
	localparam int CB_MFE       = 2;
	localparam int CB_GIE       = 3;
	// auto_conv_control fields
	localparam int AC_ENABLE    = 7;
	localparam int AC_FASTCLK   = 6;
	localparam int AC_OPAMP     = 5;
	localparam logic [7:0] AC_MASK  = 8'he3;
	localparam logic [7:0] EV_MASK  = 8'h73;
	localparam logic [7:0] NIB_MASK = 8'hf0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Conversion timing in converter clocks
	localparam int SAMPLE_CLKS  = 4;
	localparam int CONVERT_CLKS = 12;
	localparam int TOTAL_CLKS   = SAMPLE_CLKS + CONVERT_CLKS;
	localparam int RESULT_BITS  = 12;
	// Auto period base time and cycles
	localparam int CLK_MHZ      = 100;
	localparam int PERIOD_MS    = 4;
	// Milliseconds to microseconds, then system cycles per microsecond
	localparam int PERIOD_CYC   = PERIOD_MS * 1000 * CLK_MHZ;
	// Converter sequencer states
	typedef enum logic [1:0] {
		ADCACM_IDLE   = 2'b00,
		ADCACM_ARMED  = 2'b01,
		ADCACM_SAMPLE = 2'b10,
		ADCACM_CONV   = 2'b11
	} adcacm_state_e;
endpackage
`default_nettype wire

// file: core/adcacm_period_timer.sv
// Purpose: Watchdog-style free counter raising a tick at the chosen period.
// Assumes: Period selects 1x, 2x, 4x, 8x the base count.
// Notes:   Tick is one cycle wide; counter restarts while disabled.
`default_nettype none
module adcacm_period_timer #(
	parameter int BASE_CYC = adcacm_pkg::PERIOD_CYC
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [1:0] period_sel,
	output var  logic       tick
);
	typedef struct packed {
		logic [31:0] cnt; // Elapsed cycles
		logic        tick;
	} adcacm_tmr_s;
	adcacm_tmr_s st;
	adcacm_tmr_s next_st;
	logic [31:0] limit; // Terminal count
	// Doubling per select code keeps the 4/8/16/32 ms ladder exact
	always_comb begin
		limit = (32'(BASE_CYC) << period_sel) - 32'h1;
		next_st = st;
		next_st.tick = 1'b0;
		if (!run) begin
			next_st.cnt = 32'h0;
		end else if (st.cnt >= limit) begin
			next_st.cnt = 32'h0;
			next_st.tick = 1'b1; // R8
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end
	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick = st.tick;
endmodule
`default_nettype wire

// file: core/adcacm_window_check.sv
// Purpose: Compares a 12-bit result against a lower/upper window.
// Assumes: Limits are stable around the compare.
// Notes:   Registered output, one cycle after valid.
`default_nettype none
module adcacm_window_check #(
	parameter int W = adcacm_pkg::RESULT_BITS
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         valid,
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] lower,
	input  wire logic [W-1:0] upper,
	output var  logic         outside
);
	typedef struct packed {
		logic outside;
	} adcacm_win_s;
	adcacm_win_s st;
	adcacm_win_s next_st;
	// Equal to a limit counts as inside
	always_comb begin
		next_st.outside = valid && ((value < lower) || (value > upper)); // R19
	end
	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign outside = st.outside;
endmodule
`default_nettype wire

// file: core/adcacm_top.sv
// Purpose: Converter control with auto-conversion window monitor.
// Assumes: APB slave, converter core supplies data when sampled.
// Notes:   Converter clock is the system clock divided by a parameter.
//          Writes commit on the first access edge; pready follows it.
//          A period tick that lands while a conversion runs is lost.
//          Timing outputs are active high, unlike their register bits.
// How it works
// [R1] Power-off bit switches converter circuitry off
// [R2] Result is unsigned 12-bit, full scale FFF
// [R3] Start pulse: rise resets, fall begins conversion
// [R4] Done flag readable and pollable in control A
// [R5] Result split into low and high registers
// [R6] Done sets irq flag; three enables gate it
// [R7] Bit 7 enables auto conversion, resets zero
// [R8] Period tick powers and starts a conversion
// [R9] Out-of-window auto results bump 3-bit counter
// [R10] Counter hits target: interrupt, clear counter
// [R11] Target codes mean 1, 2, 4, 7 events
// [R12] Auto path runs and wakes CPU when halted
// [R13] Bit 6 fast clock timing, 0 enables
// [R14] Bit 5 opamp timing, 0 enables
// [R15] Upper limit split high byte, high nibble
// [R16] Lower limit uses same split layout
// [R17] Conversion is 4 sample plus 12 convert clocks
// [R18] Done_n high while busy, low when valid
// [R19] Only strictly outside results count
// [R20] Unimplemented bits ignore writes, read zero
//
// Decided for this implementation: the register addresses and the APB slave port.
`default_nettype none
module adcacm_top #(
	parameter int ADCLK_DIV = 8,
	parameter int BASE_CYC  = adcacm_pkg::PERIOD_CYC
) (
	// System clock and synchronous reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB register port
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Converter core side
	input  wire logic [11:0] conv_data,
	// CPU state, for the wake request
	input  wire logic        cpu_halted,
	// Converter controls, interrupts and wake
	output var  logic        conv_powered,
	output var  logic        conv_sample,
	output var  logic        fastclk_turnon_timing,
	output var  logic        opamp_turnon_timing,
	output var  logic        conv_irq,
	output var  logic        auto_irq,
	output var  logic        cpu_wake
);
	typedef struct packed {
		// Bus answer
		logic [31:0] prdata;   // Registered read data
		logic        pready;   // Access-phase answer
		logic        pslverr;  // Unmapped access
		// Software control and status
		logic        start;    // Software start bit
		logic        power_off;
		logic        done_n;   // High while busy
		logic        irq_flag; // Conversion request flag
		logic        irq_en;
		logic        multi_func_irq_enable;
		logic        gie;
		// Result, auto-conversion and limit registers
		logic [11:0] result;
		logic [7:0]  auto_ctrl;
		logic [2:0]  evt_cnt;
		logic [1:0]  evt_tgt;
		logic [7:0]  ulim_hi;
		logic [3:0]  ulim_lo;
		logic [7:0]  llim_hi;
		logic [3:0]  llim_lo;
		// Sequencer bookkeeping
		adcacm_pkg::adcacm_state_e seq; // Converter sequencer
		logic [7:0]  div;      // Converter clock prescale
		logic [4:0]  clks;     // Converter clocks since sampling began
		logic        auto_run; // Current conversion is automatic
		logic        auto_pend;// Compare result pending
		// Registered outputs
		logic        auto_irq;
		logic        cpu_wake;
		logic        conv_irq;
		logic        sample;
		logic        powered;
		logic        fast_on;  // Fast clock timing active
		logic        opamp_on; // Amplifier timing active
	} adcacm_top_s;
	adcacm_top_s st;
	adcacm_top_s next_st;
	// Glue between the register file and the helpers
	logic        tick;      // Auto period elapsed
	logic        outside;   // Registered window result
	logic        cmp_valid; // Pulse to window checker
	logic [11:0] ulim;
	logic [11:0] llim;
	logic        wr;        // APB write in access phase
	logic        rd;
	logic [2:0]  tgt_cnt;   // Decoded event target
	logic        adclk;     // Converter clock enable pulse
	// Limits assembled from split registers
	// Nibble registers supply the low four bits of each limit
	assign ulim = {st.ulim_hi, st.ulim_lo}; // R15
	assign llim = {st.llim_hi, st.llim_lo}; // R16
	// Access phase decode; the answered cycle is masked so that an
	// access held over into it is not taken a second time
	assign wr = psel && penable && pwrite && !st.pready;
	assign rd = psel && penable && !pwrite && !st.pready;
	// One converter clock per wrap of the prescaler
	assign adclk = (st.div == 8'(ADCLK_DIV - 1));
	// Only automatic results reach the window, a cycle after the conversion completes
	assign cmp_valid = st.auto_pend;
	// Period counter runs regardless of CPU halt
	// Enable bit gates it; the period code picks the multiple
	// Counter is cleared while disabled, so each enable restarts it
	adcacm_period_timer #(
		.BASE_CYC   (BASE_CYC)
	) u_timer (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.run        (st.auto_ctrl[adcacm_pkg::AC_ENABLE]),
		.period_sel (st.auto_ctrl[1:0]),
		.tick       (tick)
	);
	// Limit comparator for automatic results
	// Limits are taken as they stand when the result arrives
	adcacm_window_check #(
		.W       (adcacm_pkg::RESULT_BITS)
	) u_window (
		.clk     (clk),
		.sys_rst (sys_rst),
		.valid   (cmp_valid),
		.value   (st.result),
		.lower   (llim),
		.upper   (ulim),
		.outside (outside)
	);
	// Target code decode
	// Code 11 means seven: a 3-bit count never reaches eight
	always_comb begin
		unique case (st.evt_tgt)
			2'b00: tgt_cnt = 3'h1; // R11
			2'b01: tgt_cnt = 3'h2; // R11
			2'b10: tgt_cnt = 3'h4; // R11
			2'b11: tgt_cnt = 3'h7; // R11
		endcase
	end
	// Next-state logic: bus, sequencer and monitor
	always_comb begin
		next_st = st;
		// Bus answers and pulses last one cycle unless set again
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.auto_pend = 1'b0;
		next_st.auto_irq = 1'b0;
		// Prescaler free-runs; the sequencer restarts it when sampling begins
		next_st.div = adclk ? 8'h0 : st.div + 8'h1;
		// APB write; masks drop unimplemented bits
		if (wr) begin
			next_st.pready = 1'b1;
			unique case (paddr)
				// Start and power bits; the done flag is read-only
				adcacm_pkg::OFF_CONV_CONTROL_A: begin
					next_st.start = pwdata[adcacm_pkg::CA_START];
					next_st.power_off = pwdata[adcacm_pkg::CA_POWER_OFF];
				end
				adcacm_pkg::OFF_CONV_CONTROL_B: begin
					// Software may clear the flag only
					// Writing one keeps a pending request
					if (!pwdata[adcacm_pkg::CB_IRQ_FLAG]) begin
						next_st.irq_flag = 1'b0; // R6
					end
					next_st.irq_en = pwdata[adcacm_pkg::CB_IRQ_EN];
					next_st.multi_func_irq_enable = pwdata[adcacm_pkg::CB_MFE];
					next_st.gie = pwdata[adcacm_pkg::CB_GIE];
				end
				// Enable, timing bits and period code
				adcacm_pkg::OFF_AUTO_CTRL:
					next_st.auto_ctrl = pwdata[7:0] & adcacm_pkg::AC_MASK; // R20
				// A write may preset the count; the hardware wins a tie
				adcacm_pkg::OFF_AUTO_EVT: begin
					next_st.evt_cnt = pwdata[6:4]; // R20
					next_st.evt_tgt = pwdata[1:0];
				end
				// Limit nibbles live in the top half of their byte
				adcacm_pkg::OFF_ULIM_LO: next_st.ulim_lo = pwdata[7:4]; // R15
				adcacm_pkg::OFF_ULIM_HI: next_st.ulim_hi = pwdata[7:0]; // R15
				adcacm_pkg::OFF_LLIM_LO: next_st.llim_lo = pwdata[7:4]; // R16
				adcacm_pkg::OFF_LLIM_HI: next_st.llim_hi = pwdata[7:0]; // R16
				adcacm_pkg::OFF_RESULT_LOW,
				adcacm_pkg::OFF_RESULT_HIGH: ; // Read-only, write ignored
				// Unmapped: error answer, nothing changes
				default: next_st.pslverr = 1'b1;
			endcase
		end
		// APB read; unused bits read zero
		if (rd) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0;
			unique case (paddr)
				// Live control and status bits
				adcacm_pkg::OFF_CONV_CONTROL_A: begin
					next_st.prdata[adcacm_pkg::CA_START] = st.start;
					next_st.prdata[adcacm_pkg::CA_DONE_N] = st.done_n; // R4
					next_st.prdata[adcacm_pkg::CA_POWER_OFF] = st.power_off;
				end
				adcacm_pkg::OFF_CONV_CONTROL_B:
					next_st.prdata[3:0] = {st.gie, st.multi_func_irq_enable, st.irq_en,
						st.irq_flag};
				// Result: low nibble in bits 7..4, high byte whole
				adcacm_pkg::OFF_RESULT_LOW:
					next_st.prdata[7:0] = {st.result[3:0], 4'h0}; // R5
				adcacm_pkg::OFF_RESULT_HIGH:
					next_st.prdata[7:0] = st.result[11:4]; // R5
				// Auto registers read back only their implemented bits
				adcacm_pkg::OFF_AUTO_CTRL:
					next_st.prdata[7:0] = st.auto_ctrl; // R7
				adcacm_pkg::OFF_AUTO_EVT:
					next_st.prdata[7:0] = {1'b0, st.evt_cnt, 2'b00,
						st.evt_tgt}; // R20
				// Limits read back as written, unused bits zero
				adcacm_pkg::OFF_ULIM_LO: next_st.prdata[7:0] = {st.ulim_lo, 4'h0};
				adcacm_pkg::OFF_ULIM_HI: next_st.prdata[7:0] = st.ulim_hi;
				adcacm_pkg::OFF_LLIM_LO: next_st.prdata[7:0] = {st.llim_lo, 4'h0};
				adcacm_pkg::OFF_LLIM_HI: next_st.prdata[7:0] = st.llim_hi;
				// Unmapped read: error answer, data zero
				default: next_st.pslverr = 1'b1;
			endcase
		end
		// Converter sequencer
		unique case (st.seq)
			// Idle: a manual start outranks a period tick
			// A tick that lands while busy is dropped, not queued
			adcacm_pkg::ADCACM_IDLE: begin
				if (st.start && !st.power_off) begin
					next_st.seq = adcacm_pkg::ADCACM_ARMED; // R3
					next_st.done_n = 1'b1; // R18
					next_st.auto_run = 1'b0;
				end else if (tick) begin
					// Auto path powers the core itself, even when halted
					next_st.seq = adcacm_pkg::ADCACM_SAMPLE; // R8
					next_st.done_n = 1'b1; // R12
					next_st.auto_run = 1'b1;
					next_st.clks = 5'h0;
					next_st.div = 8'h0;
				end
			end
			adcacm_pkg::ADCACM_ARMED: begin
				// Converter held in reset until start falls
				// Power-off while armed aborts through the check below
				if (!st.start) begin
					next_st.seq = adcacm_pkg::ADCACM_SAMPLE; // R3
					next_st.clks = 5'h0;
					next_st.div = 8'h0;
				end
			end
			// Sample for four converter clocks; the core data is taken
			// on the last one, while the input is still connected
			adcacm_pkg::ADCACM_SAMPLE: begin
				if (adclk) begin
					next_st.clks = st.clks + 5'h1;
					if (st.clks == 5'(adcacm_pkg::SAMPLE_CLKS - 1)) begin
						next_st.seq = adcacm_pkg::ADCACM_CONV; // R17
						next_st.result = conv_data; // R2
					end
				end
			end
			// Twelve converter clocks, then completion is flagged
			adcacm_pkg::ADCACM_CONV: begin
				if (adclk) begin
					next_st.clks = st.clks + 5'h1;
					if (st.clks == 5'(adcacm_pkg::TOTAL_CLKS - 1)) begin
						next_st.seq = adcacm_pkg::ADCACM_IDLE; // R17
						next_st.done_n = 1'b0; // R18
						next_st.irq_flag = 1'b1; // R6
						next_st.auto_pend = st.auto_run; // R9
					end
				end
			end
		endcase
		// Power-off aborts any manual conversion
		// Automatic conversions are exempt so the monitor keeps going
		if (st.power_off && !st.auto_run &&
		    st.seq != adcacm_pkg::ADCACM_IDLE) begin
			next_st.seq = adcacm_pkg::ADCACM_IDLE; // R1
			next_st.done_n = 1'b0;
		end
		// Event counter; hardware clear wins over software write
		// Compare the incremented count so target one fires at once
		if (outside) begin
			if (st.evt_cnt + 3'h1 == tgt_cnt) begin
				next_st.evt_cnt = 3'h0; // R10
				next_st.auto_irq = 1'b1; // R10
			end else begin
				next_st.evt_cnt = st.evt_cnt + 3'h1; // R9
			end
		end
		// Outputs come from the next state so that they leave flops
		// Wake is pulsed only while the CPU is actually halted
		next_st.cpu_wake = next_st.auto_irq && cpu_halted; // R12
		next_st.conv_irq = next_st.irq_flag && next_st.irq_en &&
			next_st.multi_func_irq_enable && next_st.gie; // R6
		next_st.sample = (next_st.seq == adcacm_pkg::ADCACM_SAMPLE);
		// Powered while switched on, or for an automatic conversion
		next_st.powered = (!next_st.power_off) ||
			(next_st.seq != adcacm_pkg::ADCACM_IDLE && next_st.auto_run); // R1
		// Timing bits are enables when low
		next_st.fast_on = !next_st.auto_ctrl[adcacm_pkg::AC_FASTCLK]; // R13
		next_st.opamp_on = !next_st.auto_ctrl[adcacm_pkg::AC_OPAMP]; // R14
	end
	// State register
	// Reset leaves the converter off, idle and both timings enabled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.power_off <= 1'b1;
			st.seq <= adcacm_pkg::ADCACM_IDLE;
			st.fast_on <= 1'b1;
			st.opamp_on <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
	// Outputs straight from flops
	// Bus answer
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	// Converter controls
	assign conv_powered = st.powered;
	assign conv_sample = st.sample;
	assign fastclk_turnon_timing = st.fast_on; // R13
	assign opamp_turnon_timing = st.opamp_on; // R14
	// Interrupt side
	assign conv_irq = st.conv_irq;
	assign auto_irq = st.auto_irq;
	assign cpu_wake = st.cpu_wake;
endmodule
`default_nettype wire

// file: test/adcacm_checker.sv
// Purpose: Port-level assertions for the auto-conversion monitor.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached to the top module by the bind at the foot.
`default_nettype none
module adcacm_checker #(
	parameter int ADCLK_DIV = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_halted,
	input wire logic conv_powered,
	input wire logic conv_sample,
	input wire logic conv_irq,
	input wire logic auto_irq,
	input wire logic cpu_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	// Everything is judged on the system clock; all but AST_RESET are quiet during reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_RDY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable))
		else $error("ready without an access phase");
	AST_ERR_RDY: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	AST_WAKE: assert property (cpu_wake |-> auto_irq && $past(cpu_halted))
		else $error("wake without halted cpu and interrupt");
	AST_IRQ_PULSE: assert property (auto_irq |=> !auto_irq)
		else $error("window interrupt longer than one cycle");
	AST_SAMPLE_LEN: assert property ($rose(conv_sample) |-> conv_sample[*4])
		else $error("sampling phase cut short");
	AST_SAMPLE_PWR: assert property (conv_sample |-> conv_powered)
		else $error("sampling with converter unpowered");
	// Reset itself must clear the outputs, so no disable here
	AST_RESET: assert property (disable iff (1'b0)
		sys_rst |=> !pready && !auto_irq && !conv_irq)
		else $error("outputs not cleared by reset");
endmodule
bind adcacm_top adcacm_checker #(.ADCLK_DIV(ADCLK_DIV)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted),
	.conv_powered(conv_powered), .conv_sample(conv_sample),
	.conv_irq(conv_irq), .auto_irq(auto_irq), .cpu_wake(cpu_wake)
);
`default_nettype wire

// file: test/adcacm_conv_model.sv
// Purpose: Behavioural analog core feeding sample data.
// Assumes: Data is only meaningful while sampling.
// Notes:   Outside sampling the bus toggles so stale data is never seen.
`default_nettype none
module adcacm_conv_model (
	input  wire logic        clk,
	input  wire logic        conv_sample,
	input  wire logic [11:0] level,
	output var  logic [11:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] junk = 12'ha5a; // Changes every cycle
	// Scramble pattern, so a late capture shows up as a wrong result
	always_ff @(posedge clk) begin
		junk <= ~junk;
	end
	// Unsigned 12-bit code, full scale fff
	assign conv_data = conv_sample ? level : junk;
endmodule
`default_nettype wire

// file: test/test_adc_auto_conversion_monitor.sv
// Purpose: Self-checking bench for the auto-conversion monitor.
// Assumes: Short period and divider parameters keep the run brief.
// Notes:   Reads queue their expectation; a monitor compares on ready.
`default_nettype none
module test_adc_auto_conversion_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, sys_rst, psel, penable, pwrite, cpu_halted;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, r;
	logic        pready, pslverr, conv_powered, conv_sample, samp_d;
	logic        fast_t, opamp_t, conv_irq, auto_irq, cpu_wake;
	logic [11:0] conv_data, level;
	logic [65:0] exp_q[$], ent;
	// Poll reads check all but the busy bit, which is judged via q
	localparam logic [32:0] POLL_MASK = 33'h1ffffffbf;
	int          mismatches, check_count, cyc, n_conv, n_irq, n_wake;
	// Register write masks, auto-conversion cases
	logic [7:0]  msk [6] = '{8'he3, 8'h73, 8'hf0, 8'hff, 8'hf0, 8'hff};
	logic [11:0] lv [5] = '{12'hfff, 12'h000, 12'hfff, 12'h000, 12'h800};
	logic [1:0]  cd [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	int          ne [5] = '{7, 3, 1, 1, 0};
	logic [2:0]  lf [5] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h0};
	adcacm_top #(.ADCLK_DIV(2), .BASE_CYC(20)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_data(conv_data),
		.cpu_halted(cpu_halted), .conv_powered(conv_powered),
		.conv_sample(conv_sample), .fastclk_turnon_timing(fast_t),
		.opamp_turnon_timing(opamp_t), .conv_irq(conv_irq),
		.auto_irq(auto_irq), .cpu_wake(cpu_wake)
	);
	adcacm_conv_model u_model (
		.clk(clk), .conv_sample(conv_sample), .level(level),
		.conv_data(conv_data)
	);
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		check_count++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One APB transfer; a read leaves a masked expectation behind
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] m, input logic [32:0] e);
		if (!w) begin
			exp_q.push_back({m, e});
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 33'h0, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, {1'b1, 32'hffffffff}, {1'b0, e});
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Monitor: compares read answers, counts events, cuts hangs short
	always @(posedge clk) begin
		if (pready === 1'b1 && psel && !pwrite && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			chk({pslverr, prdata} & ent[65:33], ent[32:0]);
		end
		samp_d <= conv_sample;
		if (conv_sample === 1'b1 && samp_d === 1'b0)
			n_conv++;
		if (auto_irq === 1'b1)
			n_irq++;
		if (cpu_wake === 1'b1)
			n_wake++;
		cyc++;
		if (cyc == 20000) begin
			$display("mismatch at %0t: run timed out", $time);
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; cpu_halted = 1'b0; level = 12'h000;
		void'($urandom(79));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({fast_t, opamp_t, conv_powered}, 3'b110);
		// Reset values, then random writes through the masks
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			rd(8'h10 + 8'(4 * i), 32'h0);
			wr(8'h10 + 8'(4 * i), r);
			rd(8'h10 + 8'(4 * i), r & 32'(msk[i]));
			wr(8'h10 + 8'(4 * i), 32'h0);
		end
		wr(adcacm_pkg::OFF_AUTO_CTRL, 32'h60);
		chk({fast_t, opamp_t}, 2'b00);
		bus(1'b0, 8'h40, 32'h0, 33'h100000000, 33'h100000000);
		// Manual conversion with polling and the gated interrupt
		level <= 12'($urandom);
		wr(adcacm_pkg::OFF_CONV_CONTROL_B, 32'h0e);
		wr(adcacm_pkg::OFF_CONV_CONTROL_A, 32'h00);
		chk(conv_powered, 1'b1);
		wr(adcacm_pkg::OFF_CONV_CONTROL_A, 32'h80);
		wr(adcacm_pkg::OFF_CONV_CONTROL_A, 32'h00);
		bus(1'b0, adcacm_pkg::OFF_CONV_CONTROL_A, 32'h0, POLL_MASK,
			33'h0);
		chk(q[6], 1'b1);
		for (int k = 0; k < 40 && q[6]; k++)
			bus(1'b0, adcacm_pkg::OFF_CONV_CONTROL_A, 32'h0, POLL_MASK,
				33'h0);
		chk(q[6], 1'b0);
		rd(adcacm_pkg::OFF_RESULT_LOW, {24'h0, level[3:0], 4'h0});
		rd(adcacm_pkg::OFF_RESULT_HIGH, {24'h0, level[11:4]});
		chk(conv_irq, 1'b1);
		// Flag kept by writing one; the global enable alone masks it
		wr(adcacm_pkg::OFF_CONV_CONTROL_B, 32'h07);
		chk(conv_irq, 1'b0);
		rd(adcacm_pkg::OFF_CONV_CONTROL_B, 32'h07);
		wr(adcacm_pkg::OFF_CONV_CONTROL_B, 32'h0e);
		chk(conv_irq, 1'b0);
		rd(adcacm_pkg::OFF_CONV_CONTROL_B, 32'h0e);
		// Window 100..800, converter switched off by software
		wr(adcacm_pkg::OFF_ULIM_HI, 32'h80);
		wr(adcacm_pkg::OFF_LLIM_HI, 32'h10);
		wr(adcacm_pkg::OFF_CONV_CONTROL_A, 32'h20);
		chk(conv_powered, 1'b0);
		for (int i = 0; i < 5; i++) begin
			level <= lv[i];
			cpu_halted <= (i != 1);
			wr(adcacm_pkg::OFF_AUTO_EVT, {30'h0, cd[i]});
			n_conv = 0;
			n_irq = 0;
			n_wake = 0;
			wr(adcacm_pkg::OFF_AUTO_CTRL, 32'h83);
			wait (n_conv == 7);
			repeat (60) @(posedge clk);
			wr(adcacm_pkg::OFF_AUTO_CTRL, 32'h0);
			chk(n_irq, ne[i]);
			chk(n_wake, cpu_halted ? ne[i] : 0);
			rd(adcacm_pkg::OFF_AUTO_EVT, {25'h0, lf[i], 2'h0, cd[i]});
		end
		wrap_up();
	end
endmodule
`default_nettype wire
